//--- common/wit_defines.vh
`ifndef WIT_DEFINES_VH
`define WIT_DEFINES_VH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define WIT_IDX_MODE       18'h0ff6f
`define WIT_IDX_STATUS     18'h0ff70
`define WIT_IDX_MASK       18'h0ff71
`define WIT_IDX_SET        18'h0ff72
`define WIT_IDX_CLR        18'h0ff73
`define WIT_IDX_COUNT      18'h0ff74

// ----------------------------------------
// Mode register fields and reset value
// ----------------------------------------
`define WIT_MODE_RESET     8'h00
`define WIT_BIT_ENABLE     0
`define WIT_BIT_RUN        1
`define WIT_WSEL_LO        2
`define WIT_WSEL_HI        3
`define WIT_ISEL_LO        4
`define WIT_ISEL_HI        6
`define WIT_BIT_CLKSEL     7

// ----------------------------------------
// Watch period codes
// ----------------------------------------
`define WIT_WSEL_P14       2'h0
`define WIT_WSEL_P13       2'h1
`define WIT_WSEL_P5        2'h2
`define WIT_WSEL_P4        2'h3

// ----------------------------------------
// Status and mask layout
// ----------------------------------------
`define WIT_ST_WATCH       0
`define WIT_ST_INTERVAL    1
`define WIT_ST_RESET       2'h0

// ----------------------------------------
// Divider, prescaler and counter figures
// ----------------------------------------
`define WIT_PRS_DIV        128
`define WIT_PRE_WIDTH      11
`define WIT_CNT_WIDTH      5
`define WIT_ISEL_BASE      4
`define WIT_CNT_TAP        9

`endif

//--- logic/wit_timer.v
`timescale 1ns/1ps
`include "wit_defines.vh"

module wit_timer #(
    parameter PRS_DIV   = `WIT_PRS_DIV,
    parameter PRE_WIDTH = `WIT_PRE_WIDTH,
    parameter CNT_WIDTH = `WIT_CNT_WIDTH
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [19:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sub_clock,
    output reg         watch_interrupt_request,
    output reg         interval_interrupt_request,
    output wire        irq
);

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    localparam [17:0] IDX_MODE   = `WIT_IDX_MODE;
    localparam [17:0] IDX_STATUS = `WIT_IDX_STATUS;
    localparam [17:0] IDX_MASK   = `WIT_IDX_MASK;
    localparam [17:0] IDX_SET    = `WIT_IDX_SET;
    localparam [17:0] IDX_CLR    = `WIT_IDX_CLR;
    localparam [17:0] IDX_COUNT  = `WIT_IDX_COUNT;

    reg  [7:0]           watch_mode_control;
    reg  [1:0]           status;
    reg  [1:0]           mask;
    reg  [6:0]           div_count;
    reg                  sub_clock_q;
    reg  [PRE_WIDTH-1:0] prescaler;
    reg  [CNT_WIDTH-1:0] counter;

    wire [17:0] idx;
    wire        word_ok;
    wire        hit_mode;
    wire        hit_status;
    wire        hit_mask;
    wire        hit_set;
    wire        hit_clr;
    wire        hit_count;
    wire        mapped;
    wire        access;
    wire        wr_low;

    assign idx        = paddr[19:2];
    assign word_ok    = (paddr[1:0] == 2'h0);
    assign hit_mode   = word_ok && (idx == IDX_MODE);
    assign hit_status = word_ok && (idx == IDX_STATUS);
    assign hit_mask   = word_ok && (idx == IDX_MASK);
    assign hit_set    = word_ok && (idx == IDX_SET);
    assign hit_clr    = word_ok && (idx == IDX_CLR);
    assign hit_count  = word_ok && (idx == IDX_COUNT);
    assign mapped     = hit_mode | hit_status | hit_mask | hit_set | hit_clr | hit_count;

    // The slave never inserts wait states, so every access ends in its first
    // access-phase cycle.
    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_low  = access & pwrite & pstrb[0];

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    // Writes with pstrb[0] low are dropped, because every writable register lives in byte lane 0.
    wire wr_mode;
    wire wr_set;
    wire wr_clr;
    wire wr_status;
    wire wr_mask;

    assign wr_mode   = wr_low & hit_mode;
    assign wr_set    = wr_low & hit_set;
    assign wr_clr    = wr_low & hit_clr;
    assign wr_status = wr_low & hit_status;
    assign wr_mask   = wr_low & hit_mask;

    // ----------------------------------------
    // Mode register
    // ----------------------------------------
    wire       timer_enable_bit;
    wire       counter_run_control;
    wire [1:0] watch_period_select;
    wire [2:0] interval_select;
    wire       count_clock_select;

    assign timer_enable_bit    = watch_mode_control[`WIT_BIT_ENABLE];
    assign counter_run_control = watch_mode_control[`WIT_BIT_RUN];
    assign watch_period_select = watch_mode_control[`WIT_WSEL_HI:`WIT_WSEL_LO];
    assign interval_select     = watch_mode_control[`WIT_ISEL_HI:`WIT_ISEL_LO];
    assign count_clock_select  = watch_mode_control[`WIT_BIT_CLKSEL];

    // Whole-byte writes go to the mode register itself; the set and clear
    // aliases give single-bit writes that cannot disturb the other bits.
    reg  [7:0] next_watch_mode_control;

    always @* begin
        next_watch_mode_control = watch_mode_control;
        if (wr_mode) begin
            next_watch_mode_control = pwdata[7:0];
        end else if (wr_set) begin
            next_watch_mode_control = watch_mode_control | pwdata[7:0];
        end else if (wr_clr) begin
            next_watch_mode_control = watch_mode_control & ~pwdata[7:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            watch_mode_control <= `WIT_MODE_RESET;
        end else begin
            watch_mode_control <= next_watch_mode_control;
        end
    end

    // ----------------------------------------
    // Watch count clock
    // ----------------------------------------
    // The subsystem clock is a slow level input; its rising edge becomes a
    // one-cycle enable, so the timer stays in the single clk domain.
    localparam [31:0] DIV_LAST_W = PRS_DIV - 1;
    localparam [6:0]  DIV_LAST   = DIV_LAST_W[6:0];

    wire div_tick;
    wire sub_tick;
    wire fw_tick;

    always @(posedge clk) begin
        if (rst) begin
            div_count   <= 7'h00;
            // Following the pin through reset keeps a high pin from faking an edge.
            sub_clock_q <= sub_clock;
        end else begin
            sub_clock_q <= sub_clock;
            if (!timer_enable_bit || div_count == DIV_LAST) begin
                div_count <= 7'h00;
            end else begin
                div_count <= div_count + 7'h01;
            end
        end
    end

    assign div_tick = timer_enable_bit && (div_count == DIV_LAST);
    assign sub_tick = sub_clock & ~sub_clock_q;
    assign fw_tick  = count_clock_select ? sub_tick : div_tick;

    // ----------------------------------------
    // Prescaler stage taps
    // ----------------------------------------
    // stage_done[k] pulses when stage 2^(k+1) completes a period.
    wire [PRE_WIDTH-1:0] stage_done;

    genvar k;
    generate
        for (k = 0; k < PRE_WIDTH; k = k + 1) begin : g_tap
            assign stage_done[k] = fw_tick & (&prescaler[k:0]);
        end
    endgenerate

    reg  [PRE_WIDTH-1:0] next_prescaler;

    always @* begin
        next_prescaler = prescaler;
        if (!timer_enable_bit) begin
            next_prescaler = {PRE_WIDTH{1'b0}};
        end else if (fw_tick) begin
            // Clearing only the run bit leaves this running; that is what
            // makes the first watch period after a restart inexact.
            next_prescaler = prescaler + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prescaler <= {PRE_WIDTH{1'b0}};
        end else begin
            prescaler <= next_prescaler;
        end
    end

    // ----------------------------------------
    // Five-bit counter
    // ----------------------------------------
    wire watch_running;
    wire cnt_step;

    assign watch_running = timer_enable_bit & counter_run_control;
    assign cnt_step      = watch_running & stage_done[`WIT_CNT_TAP - 1];

    // The counter steps only on the 2^9 tap, so the two long watch periods
    // cost five flops rather than three more prescaler stages.
    reg  [CNT_WIDTH-1:0] next_counter;

    always @* begin
        next_counter = counter;
        if (!watch_running) begin
            next_counter = {CNT_WIDTH{1'b0}};
        end else if (cnt_step) begin
            next_counter = counter + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            counter <= {CNT_WIDTH{1'b0}};
        end else begin
            counter <= next_counter;
        end
    end

    // ----------------------------------------
    // Watch and interval events
    // ----------------------------------------
    reg watch_event;
    reg interval_event;

    always @* begin
        case (watch_period_select)
            `WIT_WSEL_P14: watch_event = cnt_step & (&counter);
            `WIT_WSEL_P13: watch_event = cnt_step & (&counter[CNT_WIDTH-2:0]);
            `WIT_WSEL_P5:  watch_event = watch_running & stage_done[4];
            `WIT_WSEL_P4:  watch_event = watch_running & stage_done[3];
            default:       watch_event = 1'b0;
        endcase
    end

    // Code n selects stage 2^(n+4), which is stage_done[n+3].
    always @* begin
        case (interval_select)
            3'h0:    interval_event = stage_done[3];
            3'h1:    interval_event = stage_done[4];
            3'h2:    interval_event = stage_done[5];
            3'h3:    interval_event = stage_done[6];
            3'h4:    interval_event = stage_done[7];
            3'h5:    interval_event = stage_done[8];
            3'h6:    interval_event = stage_done[9];
            3'h7:    interval_event = stage_done[10];
            default: interval_event = 1'b0;
        endcase
    end

    // The counter starts from zero while the prescaler keeps its phase, so the
    // first watch event lands off the period and every later one is exact.
    always @(posedge clk) begin
        if (rst) begin
            watch_interrupt_request    <= 1'b0;
            interval_interrupt_request <= 1'b0;
        end else begin
            watch_interrupt_request    <= watch_event;
            interval_interrupt_request <= timer_enable_bit & interval_event;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    wire [1:0] events;
    wire [1:0] clear_bits;
    wire [1:0] next_status;
    wire [1:0] next_mask;

    assign events      = {interval_interrupt_request, watch_interrupt_request};
    assign clear_bits  = wr_status ? pwdata[1:0] : 2'h0;
    // A request arriving in the cycle of its clear wins over the clear.
    assign next_status = (status & ~clear_bits) | events;
    assign next_mask   = wr_mask ? pwdata[1:0] : mask;

    always @(posedge clk) begin
        if (rst) begin
            status <= `WIT_ST_RESET;
            mask   <= `WIT_ST_RESET;
        end else begin
            status <= next_status;
            mask   <= next_mask;
        end
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    // The line is a plain level, so it drops in the cycle after software
    // clears the last unmasked status bit.
    assign irq = |(status & mask);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Read data is registered in the setup cycle and stands through the
    // access phase; the count register lets software watch the phase.
    reg  [31:0] next_prdata;

    always @* begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            if (hit_mode || hit_set || hit_clr) begin
                next_prdata = {24'h00_0000, watch_mode_control};
            end else if (hit_status) begin
                next_prdata = {30'h0000_0000, status};
            end else if (hit_mask) begin
                next_prdata = {30'h0000_0000, mask};
            end else if (hit_count) begin
                next_prdata = {11'h000, counter, 5'h00, prescaler};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // relies on software: the clock and interval selects take effect at
    // once, so changing them while running shifts the current period.

endmodule

//--- tb/wit_timer_asserts.sv
`timescale 1ns/1ps
`include "wit_defines.vh"
module wit_timer_asserts (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [19:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        watch_interrupt_request,
    input wire        interval_interrupt_request,
    input wire        irq
);
    // The enable and run bits are mirrored from bus writes, so no internal state is needed.
    reg  [1:0]  m;
    wire        acc = psel && penable;
    wire        wr  = acc && pwrite && pstrb[0];
    wire [17:0] ix  = paddr[19:2];
    wire        map = ix >= `WIT_IDX_MODE && ix <= `WIT_IDX_COUNT && paddr[1:0] == 2'h0;
    always @(posedge clk) begin
        if (rst)
            m <= 2'h0;
        else if (wr && ix == `WIT_IDX_MODE)
            m <= pwdata[1:0];
        else if (wr && ix == `WIT_IDX_SET)
            m <= m | pwdata[1:0];
        else if (wr && ix == `WIT_IDX_CLR)
            m <= m & ~pwdata[1:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_wpulse; watch_interrupt_request |=> !watch_interrupt_request; endproperty
    a_wpulse: assert property (p_wpulse) else $error("watch request too long");
    property p_ipulse; interval_interrupt_request |=> !interval_interrupt_request [*8]; endproperty
    a_ipulse: assert property (p_ipulse) else $error("interval requests too close");
    property p_ioff; !m[0] && !$past(m[0]) && !$past(m[0], 2) |-> !interval_interrupt_request; endproperty
    a_ioff: assert property (p_ioff) else $error("interval request while disabled");
    property p_woff; m != 2'h3 && $past(m) != 2'h3 && $past(m, 2) != 2'h3 |-> !watch_interrupt_request; endproperty
    a_woff: assert property (p_woff) else $error("watch request while stopped");
    property p_err; acc && !map |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_errph; !acc |-> !pslverr; endproperty
    a_errph: assert property (p_errph) else $error("error outside access phase");
    property p_rd0; acc && !pwrite && !map |-> prdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
    property p_rst; $fell(rst) |-> prdata == 32'h0 && !irq && !watch_interrupt_request; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    c_w: cover property (watch_interrupt_request);
    c_i: cover property (interval_interrupt_request);
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
endmodule
bind wit_timer wit_timer_asserts wit_timer_asserts_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .watch_interrupt_request(watch_interrupt_request),
    .interval_interrupt_request(interval_interrupt_request), .irq(irq));

//--- tb/wit_intc_model.sv
`timescale 1ns/1ps
module wit_intc_model (
    input  wire        clk,
    input  wire        rst,
    input  wire        wreq,
    input  wire        ireq,
    output reg  [31:0] wcnt,
    output reg  [31:0] icnt,
    output reg  [31:0] wper,
    output reg  [31:0] iper
);
    // Periods are kept in clock cycles between the two latest requests of each kind.
    reg [31:0] now;
    reg [31:0] wlast;
    reg [31:0] ilast;
    always @(posedge clk) begin
        if (rst) begin
            now <= 32'h0;
            wcnt <= 32'h0;
            icnt <= 32'h0;
        end else begin
            now <= now + 32'h1;
            if (wreq) begin
                wcnt <= wcnt + 32'h1;
                wper <= now - wlast;
                wlast <= now;
            end
            if (ireq) begin
                icnt <= icnt + 32'h1;
                iper <= now - ilast;
                ilast <= now;
            end
        end
    end
endmodule

//--- tb/tb_watch_and_interval_timer.sv
`timescale 1ns/1ps
`include "wit_defines.vh"
module tb_watch_and_interval_timer;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [19:0] paddr = 20'h0;
    reg  [31:0] pwdata = 32'h0;
    reg  [3:0]  pstrb = 4'h1;
    reg         sub_clock = 1'b0;
    reg  [31:0] q;
    reg         e;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        wreq;
    wire        ireq;
    wire        irq;
    wire [31:0] wcnt;
    wire [31:0] icnt;
    wire [31:0] wper;
    wire [31:0] iper;
    integer     errors = 0;
    integer     samples_checked = 0;
    integer     k;
    integer     s;
    integer     t;
    always #12.5 clk = ~clk;
    // A subsystem tick lands every second clock, the fastest rate the sampler can see.
    always @(posedge clk) sub_clock <= ~sub_clock;
    wit_timer #(.PRS_DIV(4)) wit_timer_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sub_clock(sub_clock), .watch_interrupt_request(wreq),
        .interval_interrupt_request(ireq), .irq(irq));
    wit_intc_model wit_intc_model_i (.clk(clk), .rst(rst), .wreq(wreq), .ireq(ireq), .wcnt(wcnt),
        .icnt(icnt), .wper(wper), .iper(iper));
    task chk(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input [17:0] i, input w, input [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitc(input w, input integer n);
        for (k = 0; k < 70000 && (w ? wcnt : icnt) < n; k = k + 1) @(posedge clk);
        if (k == 70000) errors = errors + 1;
    endtask
    task restart(input [7:0] mode);
        apb(`WIT_IDX_MODE, 1'b1, 8'h00);
        apb(`WIT_IDX_MODE, 1'b1, mode);
    endtask
    task conclude;
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #2250000;
        errors = errors + 1;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (s = 0; s < 6; s = s + 1) begin
            apb(`WIT_IDX_MODE + s, 1'b0, 8'h00);
            chk(q, 32'h0);
        end
        apb(18'h0ff75, 1'b0, 8'h00);
        chk({e, q[30:0]}, 32'h80000000);
        chk(pready, 1'b1);
        pstrb <= 4'h0;
        apb(`WIT_IDX_MODE, 1'b1, 8'hff);
        pstrb <= 4'h1;
        apb(`WIT_IDX_MODE, 1'b0, 8'h00);
        chk(q, 32'h0);
        apb(`WIT_IDX_SET, 1'b1, 8'h04);
        apb(`WIT_IDX_MODE, 1'b0, 8'h00);
        chk(q, 32'h4);
        apb(`WIT_IDX_CLR, 1'b1, 8'h04);
        apb(`WIT_IDX_MODE, 1'b0, 8'h00);
        chk(q, 32'h0);
        for (s = 0; s < 8; s = s + 1) begin
            restart(8'h81 | (s << 4));
            t = icnt;
            waitc(1'b0, t + 2);
            chk(iper, 2 << (s + 4));
        end
        restart(8'h01);
        t = icnt;
        waitc(1'b0, t + 2);
        chk(iper, 32'd64);
        for (s = 1; s < 4; s = s + 1) begin
            restart(8'h83 | (s << 2));
            t = wcnt;
            waitc(1'b1, t + 2);
            chk(wper, s == 1 ? 32'd16384 : s == 2 ? 32'd64 : 32'd32);
        end
        apb(`WIT_IDX_CLR, 1'b1, 8'h02);
        repeat (2) @(posedge clk);
        t = wcnt;
        s = icnt;
        repeat (200) @(posedge clk);
        chk(wcnt, t);
        chk(icnt > s, 1);
        apb(`WIT_IDX_COUNT, 1'b0, 8'h00);
        chk(q[20:16], 5'h0);
        apb(`WIT_IDX_MODE, 1'b1, 8'h00);
        apb(`WIT_IDX_COUNT, 1'b0, 8'h00);
        chk(q, 32'h0);
        restart(8'h83);
        t = wcnt;
        waitc(1'b1, t + 1);
        chk(k >= 31740 && k <= 33800, 1);
        apb(`WIT_IDX_MODE, 1'b1, 8'h00);
        apb(`WIT_IDX_STATUS, 1'b1, 8'h03);
        apb(`WIT_IDX_MODE, 1'b1, 8'h81);
        t = icnt;
        waitc(1'b0, t + 1);
        apb(`WIT_IDX_STATUS, 1'b0, 8'h00);
        chk({q[31:1], irq}, 32'h2);
        apb(`WIT_IDX_MASK, 1'b1, 8'h02);
        @(negedge clk);
        chk(irq, 1'b1);
        apb(`WIT_IDX_STATUS, 1'b1, 8'h02);
        @(negedge clk);
        chk(irq, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(`WIT_IDX_MODE, 1'b0, 8'h00);
        chk({q[31:1], irq}, 32'h0);
        conclude;
    end
endmodule
